// ==== dv/ecm_far_end.sv ====
// Purpose: Remote terminal model sending a framed bit 1 check stream
// Assumes: bit_en pulses once per line bit on pclk
// Notes:   flip spoils one payload bit per half; e_zero sends E bits as 0
`timescale 1ns/10ps
module ecm_far_end
	import ecm_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Commands from the bench
	input  wire logic bit_en,
	input  wire logic flip,
	input  wire logic e_zero,
	// Line side
	output logic      line_bit,
	output logic      mf_start,
	output logic      e_zero_sent
);
	logic [11:0] pos_q;
	logic [3:0]  run_q;
	logic [3:0]  hold_q;
	logic [16:0] prbs_q;
	logic [3:0]  frm;
	logic [7:0]  bt;
	logic        clean;
	logic        d;
	logic [3:0]  nxt;

	// ----------------------------------------------------------------
	// Bit composer
	// ----------------------------------------------------------------
	// Remainder is built on the clean bit so a flipped bit shows as an error
	always_comb
	begin
		frm = pos_q[11:8];
		bt  = pos_q[7:0];
		if (bt != 8'h00)
			clean = (bt > 8'h07) ? prbs_q[0] : (frm[0] ? (bt != 8'h02) : FAS[7 - bt]);
		else if (!frm[0])
			clean = hold_q[3 - frm[2:1]];
		else if (frm < 4'hD)
			clean = MFAS[5 - frm[3:1]];
		else
			clean = !e_zero;
		d           = (bt == 8'h00 && !frm[0]) ? 1'b0 : clean;
		nxt         = (bt == 8'h00 && frm[2:0] == 3'h0) ? 4'h0 : run_q;
		nxt         = {nxt[2:0], 1'b0} ^ ((d ^ nxt[3]) ? 4'h3 : 4'h0);
		line_bit    = clean ^ (flip && bt == 8'h64 && frm[2:0] == 3'h0);
		mf_start    = (pos_q == 12'h000);
		e_zero_sent = e_zero && bt == 8'h00 && frm[0] && frm > 4'hC;
	end

	// ----------------------------------------------------------------
	// Position, scrambler and remainder
	// ----------------------------------------------------------------
	// One step per line bit; the held remainder feeds the next half
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pos_q  <= 12'h000;
			run_q  <= 4'h0;
			hold_q <= 4'h0;
			prbs_q <= 17'h1ACE1;
		end
		else if (bit_en)
		begin
			pos_q  <= pos_q + 12'h001;
			prbs_q <= {prbs_q[15:0], prbs_q[16] ^ prbs_q[13]};
			run_q  <= nxt;
			if (bt == 8'hFF && frm[2:0] == 3'h7)
				hold_q <= nxt;
		end
	end
endmodule // ecm_far_end

// ==== dv/test_e1_crc4_multiframe_bit1.sv ====
// Purpose: Self-checking bench for the bit 1 check multiframe block
// Assumes: One line bit every two clocks on both directions
// Notes:   Mode changes only between multiframes, so the model stays exact
`timescale 1ns/10ps
module test_e1_crc4_multiframe_bit1;
	import ecm_pkg::*;
	logic              pclk    = 1'b0;
	logic              presetn = 1'b0;
	logic              psel    = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite  = 1'b0;
	logic [ADDR_W-1:0] paddr   = 8'h00;
	logic [31:0]       pwdata  = 32'h0;
	logic              en      = 1'b0;
	logic              pay     = 1'b0;
	logic              bas     = 1'b0;
	logic              mfa     = 1'b0;
	logic              flip    = 1'b0;
	logic              ez      = 1'b0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              tx_line_bit;
	logic              tx_mf_start;
	logic              rx_line_bit;
	logic              rx_mf_start;
	logic              e_sent;
	logic              chkd;
	logic              errd;
	logic [16:0]       lfsr    = 17'd95580;
	logic [31:0]       ctrl_m  = 32'h1F0;
	logic [31:0]       rd;
	logic              err;
	logic [3:0]        rem     = 4'h0;
	logic [3:0]        hold    = 4'h0;
	int                mismatches, samples_checked, cycles, inj, tx_zero, rx_ez, n_chk, n_err, halves;

	always #25 pclk = ~pclk;

	ecm_crc4_mf ecm_crc4_mf_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_bit_en(en), .tx_payload(pay), .tx_line_bit(tx_line_bit),
		.tx_mf_start(tx_mf_start), .rx_bit_en(en), .rx_line_bit(rx_line_bit), .rx_mf_start(rx_mf_start),
		.rx_basic_aligned(bas), .rx_mf_aligned(mfa), .rx_smf_checked(chkd), .rx_smf_errored(errd));

	ecm_far_end ecm_far_end_inst (.pclk(pclk), .presetn(presetn), .bit_en(en), .flip(flip), .e_zero(ez),
		.line_bit(rx_line_bit), .mf_start(rx_mf_start), .e_zero_sent(e_sent));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
			mismatches++;
		if (wr && a == OFS_CTRL)
			ctrl_m = wd;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Expected transmit bit; E bits in aligned use only budget-checked
	task automatic txbit(input logic [11:0] p, input logic sent);
		logic [3:0] f;
		logic [7:0] b;
		logic       o;
		f = p[11:8];
		b = p[7:0];
		o = tx_line_bit;
		chk(tx_mf_start, p == 12'h000);
		if (b != 8'h00)
			chk(o, b > 8'h07 ? sent : (f[0] ? (b == 8'h01 ? 1'b1 : (b == 8'h02 ? ctrl_m[2] : ctrl_m[11 - b])) : FAS[7 - b]));
		else if (ctrl_m[CTRL_CRCOFF])
			chk(o, 1'b1);
		else if (!f[0] && halves > 0)
			chk(o, hold[3 - f[2:1]]);
		else if (f[0] && f < 4'hD)
			chk(o, MFAS[5 - f[3:1]]);
		else if (f[0] && (ctrl_m[CTRL_EOFF] || !(bas && mfa)))
			chk(o, ctrl_m[CTRL_EOFF]);
		else if (f[0] && o === 1'b0)
		begin
			tx_zero++;
			chk(tx_zero <= inj, 1'b1);
		end
		rem = (b == 8'h00 && f[2:0] == 3'h0) ? 4'h0 : rem;
		rem = {rem[2:0], 1'b0} ^ ((((b == 8'h00 && !f[0]) ? 1'b0 : o) ^ rem[3]) ? 4'h3 : 4'h0);
		if (b == 8'hFF && f[2:0] == 3'h7)
		begin
			hold = rem;
			halves++;
		end
	endtask

	// Two clocks per bit: raise enable, drop it, then look at the output
	task automatic stream(input int mfs);
		int   p;
		logic sent;
		for (p = 0; p < mfs * 4096; p++)
		begin
			sent = lfsr[0];
			en   <= 1'b1;
			pay  <= sent;
			lfsr = lfsr_next(lfsr);
			@(posedge pclk);
			en <= 1'b0;
			if (e_sent === 1'b1 && mfa && !ctrl_m[CTRL_CRCOFF])
				rx_ez++;
			@(posedge pclk);
			txbit(p[11:0], sent);
		end
	endtask

	// ----------------------------------------------------------------
	// Monitor, timeout and main sequence
	// ----------------------------------------------------------------
	always @(posedge pclk)
	begin
		cycles++;
		if (chkd === 1'b1)
			n_chk++;
		if (errd === 1'b1)
			n_err++;
		if (errd === 1'b1)
			chk(chkd, 1'b1);
		if (cycles == 90000)
		begin
			mismatches++;
			summarize();
		end
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(OFS_CTRL, 32'h1F0);
		rdchk(OFS_STAT, 32'h0);
		rdchk(8'h14, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF);
		chk(err, 1'b1);
		stream(1);
		apb(1'b1, OFS_CTRL, 32'h156);
		rdchk(OFS_CTRL, 32'h156);
		stream(1);
		apb(1'b1, OFS_CTRL, 32'h1F0);
		bas <= 1'b1;
		mfa <= 1'b1;
		stream(1);
		rdchk(OFS_STAT, 32'h3);
		apb(1'b1, OFS_SMFERR, 32'h0);
		apb(1'b1, OFS_FEBE, 32'h0);
		apb(1'b1, OFS_SMFCNT, 32'h0);
		n_chk = 0;
		n_err = 0;
		rx_ez = 0;
		inj   = 4;
		flip <= 1'b1;
		stream(1);
		ez <= 1'b1;
		stream(1);
		flip <= 1'b0;
		stream(1);
		ez <= 1'b0;
		stream(1);
		rdchk(OFS_SMFERR, inj);
		chk(n_err, inj);
		rdchk(OFS_SMFCNT, 32'h8);
		chk(n_chk, 8);
		rdchk(OFS_FEBE, rx_ez);
		chk(rx_ez, 4);
		chk(tx_zero, inj);
		rdchk(OFS_STAT, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h1F1);
		n_chk = 0;
		stream(1);
		chk(n_chk, 0);
		summarize();
	end
endmodule // test_e1_crc4_multiframe_bit1

// ==== hdl/ecm_crc4.sv ====
// Purpose: Serial remainder of one 2048-bit block
// Assumes: start is high with the first bit of a block
// Notes:   rem_d is the remainder including the present bit
`timescale 1ns/10ps
module ecm_crc4
	import ecm_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Serial data
	input  wire logic              en,
	input  wire logic              start,
	input  wire logic              din,
	// Running remainder
	output logic [CHK_BITS-1:0]    rem_d
);
	logic [CHK_BITS-1:0] rem_q;

	// A fresh block starts from a zero remainder
	assign rem_d = crc4_step(start ? 4'h0 : rem_q, din);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rem_q <= '0;
		else if (en)
			rem_q <= rem_d;
	end
endmodule // ecm_crc4

// ==== hdl/ecm_crc4_mf.sv ====
// Purpose: Bit 1 check multiframe insertion and checking with APB control
// Assumes: Bit enables and alignment levels come from logic on pclk
// Notes:   Multiframe alignment search is done by the framer outside
// Functional notes
// - Manual mode forces bit 1 to one
// - Sixteen frames, two eight-frame halves
// - Each half of 2048 bits is one block
// - Check bits first to last in even frames
// - Pattern 001011 in odd frames, E in 13,15
// - E bits zero until both alignments held
// - E normally one, one zero per error
// - Error reported in E within one second
// - Count received E bits always; only zero E bits are counted, and only with rx_mf_aligned and manual mode off
// - E function unused sends ones
// - Remainder of x^4 times block mod x^4+x+1
// - First bit most significant, first check MSB
// - Transmit check positions taken as zero
// - Remainder held for next half's check bits
// - Receive check positions zeroed for remainder
// - Compare with next half, exact match only
// - Frame of 256 bits at 8000 per second
// - Odd frame bit 3 carries remote alarm
// - Spare national bits sent from control, default ones
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module ecm_crc4_mf
	import ecm_pkg::*;
#(
	parameter int CNT_W      = 16,
	parameter int PEND_W     = 4,
	parameter int REPORT_CYC = ecm_pkg::ERR_REPORT_CYC
)(
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Transmit stream
	input  wire logic                tx_bit_en,
	input  wire logic                tx_payload,
	output logic                     tx_line_bit,
	output logic                     tx_mf_start,
	// Receive stream
	input  wire logic                rx_bit_en,
	input  wire logic                rx_line_bit,
	input  wire logic                rx_mf_start,
	input  wire logic                rx_basic_aligned,
	input  wire logic                rx_mf_aligned,
	output logic                     rx_smf_checked,
	output logic                     rx_smf_errored
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (CNT_W < 1 || CNT_W > 32 || PEND_W < 1 || PEND_W > 4 || REPORT_CYC < 1)
		$error("ecm_crc4_mf: unsupported parameter value");

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [31:0]          prdata_q;
	logic                 pready_q;
	logic                 pslverr_q;
	logic                 crc_off_q;
	logic                 e_off_q;
	logic                 rai_q;
	logic [4:0]           spare_q;
	logic [CNT_W-1:0]     smf_err_cnt_q;
	logic [CNT_W-1:0]     febe_cnt_q;
	logic [CNT_W-1:0]     smf_cnt_q;
	logic [PEND_W-1:0]    pend_q;
	logic [31:0]          age_q;
	logic                 tx_line_q;
	logic                 tx_mf_q;
	logic [CHK_BITS-1:0]  crc_hold_q;
	logic [CHK_BITS-1:0]  rx_chk_q;
	logic [CHK_BITS-1:0]  rx_calc_q;
	logic                 rx_calc_vld_q;
	logic                 chk_q;
	logic                 err_q;
	logic [BIT_W-1:0]     tb;
	logic [FRM_W-1:0]     tf;
	logic [BIT_W-1:0]     rb;
	logic [FRM_W-1:0]     rf;
	logic [CHK_BITS-1:0]  tx_rem_d;
	logic [CHK_BITS-1:0]  rx_rem_d;
	logic                 aligned;
	logic                 wr_en;
	logic                 rd_en;
	logic                 tx_chk_slot;
	logic                 tx_e_slot;
	logic                 tx_smf_first;
	logic                 tx_smf_last;
	logic                 mfas_bit;
	logic                 chk_bit;
	logic                 e_val;
	logic                 tx_bit_d;
	logic                 e_zero_sent;
	logic                 rx_chk_slot;
	logic                 rx_e_slot;
	logic                 rx_smf_first;
	logic                 rx_smf_last;
	logic                 smf_err_evt;
	logic                 febe_evt;
	logic                 clr_smf_err;
	logic                 clr_febe;
	logic                 clr_smf_cnt;

	assign aligned = rx_basic_aligned && rx_mf_aligned;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable;

	// ----------------------------------------------------------------
	// Position trackers and remainder engines
	// ----------------------------------------------------------------
	// Transmit side free runs; its phase is shown on tx_mf_start
	ecm_pos u_tx_pos (.pclk(pclk), .presetn(presetn), .en(tx_bit_en), .sync(1'b0),
		.bit_idx(tb), .frame_idx(tf));
	ecm_pos u_rx_pos (.pclk(pclk), .presetn(presetn), .en(rx_bit_en), .sync(rx_mf_start),
		.bit_idx(rb), .frame_idx(rf));
	ecm_crc4 u_tx_crc (.pclk(pclk), .presetn(presetn), .en(tx_bit_en), .start(tx_smf_first),
		.din(tx_chk_slot ? 1'b0 : tx_bit_d), .rem_d(tx_rem_d));
	ecm_crc4 u_rx_crc (.pclk(pclk), .presetn(presetn), .en(rx_bit_en), .start(rx_smf_first),
		.din(rx_chk_slot ? 1'b0 : rx_line_bit), .rem_d(rx_rem_d));

	// ----------------------------------------------------------------
	// Transmit bit composition
	// ----------------------------------------------------------------
	// Slot decode; each half of eight frames is one block
	assign tx_chk_slot  = (tb == '0) && !tf[0];
	assign tx_e_slot    = (tb == '0) && tf[0] && (tf[3:1] >= E_FRM_HI);
	assign tx_smf_first = (tb == '0) && (tf[2:0] == '0);
	assign tx_smf_last  = (tb == BIT_W'(FRAME_BITS - 1)) && (tf[2:0] == 3'(SMF_FRAMES - 1));
	assign mfas_bit     = (tf[3:1] < 3'(MFAS_LEN)) ? MFAS[3'(MFAS_LEN - 1) - tf[3:1]] : 1'b1;
	assign chk_bit      = crc_hold_q[2'(CHK_BITS - 1) - tf[2:1]];
	assign e_zero_sent  = tx_bit_en && tx_e_slot && !crc_off_q && !e_off_q && aligned && (pend_q != '0);

	// Unused E function wins over the alignment hold-off
	always_comb
	begin
		if (e_off_q)
			e_val = 1'b1;
		else if (!aligned)
			e_val = 1'b0;
		else
			e_val = (pend_q == '0);
	end

	// Bits 1 to 8 of each frame, payload elsewhere
	always_comb
	begin
		tx_bit_d = tx_payload;
		if (tb == '0)
		begin
			if (crc_off_q)
				tx_bit_d = 1'b1;
			else if (!tf[0])
				tx_bit_d = chk_bit;
			else if (tx_e_slot)
				tx_bit_d = e_val;
			else
				tx_bit_d = mfas_bit;
		end
		else if (tb < BIT_W'(HDR_BITS))
		begin
			if (!tf[0])
				tx_bit_d = FAS[3'(HDR_BITS - 1) - tb[2:0]];
			else if (tb == BIT_W'(1))
				tx_bit_d = 1'b1;
			else if (tb == BIT_W'(2))
				tx_bit_d = rai_q;
			else
				tx_bit_d = spare_q[3'(HDR_BITS - 1) - tb[2:0]];
		end
	end

	// Line output and multiframe marker
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_line_q <= 1'b1;
			tx_mf_q   <= 1'b0;
		end
		else if (tx_bit_en)
		begin
			tx_line_q <= tx_bit_d;
			tx_mf_q   <= (tb == '0) && (tf == '0);
		end
	end

	// Remainder of the finished half goes out in the next one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			crc_hold_q <= '0;
		else if (tx_bit_en && tx_smf_last)
			crc_hold_q <= tx_rem_d;
	end

	// ----------------------------------------------------------------
	// Receive checking
	// ----------------------------------------------------------------
	assign rx_chk_slot  = (rb == '0) && !rf[0];
	assign rx_e_slot    = (rb == '0) && rf[0] && (rf[3:1] >= E_FRM_HI);
	assign rx_smf_first = (rb == '0) && (rf[2:0] == '0);
	assign rx_smf_last  = (rb == BIT_W'(FRAME_BITS - 1)) && (rf[2:0] == 3'(SMF_FRAMES - 1));
	assign smf_err_evt  = rx_bit_en && rx_smf_last && rx_mf_aligned && rx_calc_vld_q && !crc_off_q
		&& (rx_chk_q != rx_calc_q);
	assign febe_evt     = rx_bit_en && rx_e_slot && rx_mf_aligned && !crc_off_q && !rx_line_bit;

	// Received check bits gather first to last, MSB first
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_chk_q <= '0;
		else if (rx_bit_en && rx_chk_slot)
			rx_chk_q <= {rx_chk_q[CHK_BITS-2:0], rx_line_bit};
	end

	// Stored remainder is compared with the next half's check bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_calc_q     <= '0;
			rx_calc_vld_q <= 1'b0;
			chk_q         <= 1'b0;
			err_q         <= 1'b0;
		end
		else
		begin
			chk_q <= rx_bit_en && rx_smf_last && rx_mf_aligned && rx_calc_vld_q && !crc_off_q;
			err_q <= smf_err_evt;
			if (!rx_mf_aligned)
				rx_calc_vld_q <= 1'b0;
			else if (rx_bit_en && rx_smf_last)
			begin
				rx_calc_q     <= rx_rem_d;
				rx_calc_vld_q <= 1'b1;
			end
		end
	end

	// Errored halves waiting for an E bit; one zero per error
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_q <= '0;
		else if (!aligned || e_off_q || crc_off_q)
			pend_q <= '0;
		else if (smf_err_evt && !e_zero_sent && (pend_q != '1))
			pend_q <= pend_q + PEND_W'(1);
		else if (!smf_err_evt && e_zero_sent)
			pend_q <= pend_q - PEND_W'(1);
	end

	// Cycles since errors became pending or since the last E zero sent
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			age_q <= '0;
		else if (pend_q == '0 || e_zero_sent)
			age_q <= '0;
		else if (age_q != '1)
			age_q <= age_q + 32'h1;
	end

	// ----------------------------------------------------------------
	// APB registers
	// ----------------------------------------------------------------
	// Control fields steer the transmit composition
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_off_q <= 1'b0;
			e_off_q   <= 1'b0;
			rai_q     <= 1'b0;
			spare_q   <= SPARE_RST;
		end
		else if (wr_en && paddr == OFS_CTRL)
		begin
			crc_off_q <= pwdata[CTRL_CRCOFF];
			e_off_q   <= pwdata[CTRL_EOFF];
			rai_q     <= pwdata[CTRL_RAI];
			spare_q   <= pwdata[CTRL_SPHI:CTRL_SPLO];
		end
	end

	assign clr_smf_err = wr_en && (paddr == OFS_SMFERR);
	assign clr_febe    = wr_en && (paddr == OFS_FEBE);
	assign clr_smf_cnt = wr_en && (paddr == OFS_SMFCNT);

	// Write clears; an event in the same cycle still counts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			smf_err_cnt_q <= '0;
			febe_cnt_q    <= '0;
			smf_cnt_q     <= '0;
		end
		else
		begin
			smf_err_cnt_q <= (clr_smf_err ? '0 : smf_err_cnt_q) + CNT_W'(smf_err_evt);
			febe_cnt_q    <= (clr_febe ? '0 : febe_cnt_q) + CNT_W'(febe_evt);
			smf_cnt_q     <= (clr_smf_cnt ? '0 : smf_cnt_q) + CNT_W'(chk_q);
		end
	end

	// Read data captured in setup so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= rd_en;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
			if (rd_en)
			begin
				unique case (paddr)
					OFS_CTRL:
						prdata_q <= {23'h0, spare_q, 1'b0, rai_q, e_off_q, crc_off_q};
					OFS_STAT:
						prdata_q <= {24'h0, 4'(pend_q), 1'b0, pend_q != '0, rx_mf_aligned, rx_basic_aligned};
					OFS_SMFERR:
						prdata_q <= 32'(smf_err_cnt_q);
					OFS_FEBE:
						prdata_q <= 32'(febe_cnt_q);
					OFS_SMFCNT:
						prdata_q <= 32'(smf_cnt_q);
					default:
						pslverr_q <= 1'b1; // Unmapped answers with an error
				endcase
			end
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign tx_line_bit    = tx_line_q;
	assign tx_mf_start    = tx_mf_q;
	assign rx_smf_checked = chk_q;
	assign rx_smf_errored = err_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	crc_off_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bit_en && crc_off_q && tb == '0 |=> tx_line_q == 1'b1)
		else $error("bit 1 not forced high in manual mode");
	check_bit_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bit_en && !crc_off_q && tx_chk_slot |=> tx_line_q == $past(chk_bit))
		else $error("check bit out of order");
	mfas_pattern_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bit_en && !crc_off_q && tb == '0 && tf[0] && !tx_e_slot |=> tx_line_q == $past(mfas_bit))
		else $error("multiframe pattern bit wrong");
	e_hold_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bit_en && !crc_off_q && tx_e_slot && !e_off_q && !aligned |=> !tx_line_q)
		else $error("E bit not zero before alignment");
	e_unused_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bit_en && !crc_off_q && tx_e_slot && e_off_q |=> tx_line_q)
		else $error("unused E bit not one");
	e_report_age_a: assert property (@(posedge pclk) disable iff (!presetn)
		age_q < 32'(REPORT_CYC))
		else $error("errored block not reported in time");
	fas_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bit_en && !tf[0] && tb == BIT_W'(3) |=> tx_line_q == FAS[4])
		else $error("alignment pattern bit wrong");
	rai_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bit_en && tf[0] && tb == BIT_W'(2) |=> tx_line_q == $past(rai_q))
		else $error("remote alarm bit wrong");
	smf_err_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
		smf_err_evt && !clr_smf_err |=> smf_err_cnt_q == $past(smf_err_cnt_q) + CNT_W'(1))
		else $error("errored block count not advanced");
	febe_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
		febe_evt && !clr_febe |=> febe_cnt_q == $past(febe_cnt_q) + CNT_W'(1))
		else $error("received E bit not counted");
endmodule // ecm_crc4_mf

// ==== hdl/ecm_pkg.sv ====
// Purpose: Shared constants and helpers for the bit 1 check multiframe block
// Assumes: 2048 kbit/s frame, one system clock at 20 MHz
// Notes:   Register offsets are byte addresses on a 32-bit APB bus
package ecm_pkg;

	// ----------------------------------------------------------------
	// Frame geometry
	// ----------------------------------------------------------------
	localparam int          FRAME_BITS = 256;
	localparam int          SMF_FRAMES = 8;
	localparam int          MF_FRAMES  = 16;
	localparam int          POS_W      = 12;
	localparam int          BIT_W      = 8;
	localparam int          FRM_W      = 4;
	localparam int          CHK_BITS   = 4;
	localparam int          MFAS_LEN   = 6;
	localparam int          HDR_BITS   = 8;
	localparam logic [5:0]  MFAS       = 6'h0B;
	localparam logic [6:0]  FAS        = 7'h1B;
	localparam logic [3:0]  CRC_POLY   = 4'h3;
	localparam logic [2:0]  E_FRM_HI   = 3'h6;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_STAT   = 8'h04;
	localparam logic [7:0]  OFS_SMFERR = 8'h08;
	localparam logic [7:0]  OFS_FEBE   = 8'h0C;
	localparam logic [7:0]  OFS_SMFCNT = 8'h10;
	localparam int          CTRL_CRCOFF = 0;
	localparam int          CTRL_EOFF   = 1;
	localparam int          CTRL_RAI    = 2;
	localparam int          CTRL_SPLO   = 4;
	localparam int          CTRL_SPHI   = 8;
	localparam logic [4:0]  SPARE_RST   = 5'h1F;
	localparam int          STAT_BAS    = 0;
	localparam int          STAT_MFA    = 1;
	localparam int          STAT_PEND   = 2;
	localparam int          STAT_CNTLO  = 4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ         = 20_000_000;
	localparam int          ERR_REPORT_S   = 1;
	localparam int          ERR_REPORT_CYC = ERR_REPORT_S * CLK_HZ;

	// One serial step of the x^4+x+1 division, first bit most significant
	function automatic logic [3:0] crc4_step(input logic [3:0] r, input logic d);
		logic fb;
		fb = d ^ r[3];
		crc4_step = {r[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
	endfunction

endpackage

// ==== hdl/ecm_pos.sv ====
// Purpose: Bit and frame position within the 16-frame check multiframe
// Assumes: en marks one line bit; sync marks bit 1 of frame 0
// Notes:   Position wraps at 4096 bits, 16 frames of 256 bits
`timescale 1ns/10ps
module ecm_pos
	import ecm_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Bit timing
	input  wire logic              en,
	input  wire logic              sync,
	// Position of the current bit
	output logic [BIT_W-1:0]       bit_idx,
	output logic [FRM_W-1:0]       frame_idx
);
	logic [POS_W-1:0] pos_q;
	logic [POS_W-1:0] cur;

	// Sync forces the present bit to position zero
	assign cur       = sync ? '0 : pos_q;
	assign bit_idx   = cur[BIT_W-1:0];
	assign frame_idx = cur[POS_W-1:BIT_W];

	// Free running count, natural wrap gives the 16-frame cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pos_q <= '0;
		else if (en)
			pos_q <= cur + POS_W'(1);
	end
endmodule // ecm_pos
